// ===== inc/config_loader_regs.svh
`ifndef CONFIG_LOADER_REGS_SVH
`define CONFIG_LOADER_REGS_SVH

// ==========================================================
// Clock rates and derived cycle counts
`define CL_SYS_CLK_KHZ      100000
`define CL_POR_FAST_MS      3
`define CL_POR_STD_MS       50
`define CL_POR_FAST_CYC     (`CL_POR_FAST_MS * `CL_SYS_CLK_KHZ)
`define CL_POR_STD_CYC      (`CL_POR_STD_MS * `CL_SYS_CLK_KHZ)
`define CL_RESTART_US       80
`define CL_RESTART_CYC      ((`CL_RESTART_US * `CL_SYS_CLK_KHZ) / 1000)
`define CL_CE_PULSE_NS      1000
`define CL_CE_PULSE_CYC     ((`CL_CE_PULSE_NS * `CL_SYS_CLK_KHZ + 999999) / 1000000)
`define CL_CFG_CLK_KHZ      40000
`define CL_CFG_CLK_CYC      ((`CL_SYS_CLK_KHZ + `CL_CFG_CLK_KHZ - 1) / `CL_CFG_CLK_KHZ)
`define CL_INIT_OSC_KHZ     10000
`define CL_INIT_OSC_CYC     (`CL_SYS_CLK_KHZ / `CL_INIT_OSC_KHZ)
`define CL_INIT_CYCLES      3180
`define CL_STRAP_CYC        4

// ==========================================================
// Flash read timing, in system cycles
`define CL_AVD_CYC          `CL_CFG_CLK_CYC
`define CL_OE_WAIT_CYC      8

// ==========================================================
// Bus widths, start address, header word layout
`define CL_ADDR_W           24
`define CL_DATA_W           16
`define CL_FLASH_START_ADDR 24'h00_0000
`define CL_HDR_SYNC_MSB     15
`define CL_HDR_SYNC_LSB     8
`define CL_HDR_SYNC         8'h5A
`define CL_HDR_INITDONE_BIT 0

`endif

// ===== inc/config_loader_pkg.sv
package config_loader_pkg;

  // ==========================================================
  // Sequencer stages
  typedef enum logic [3:0] {
    ST_POR,
    ST_RESET,
    ST_ADDR,
    ST_DATA,
    ST_DONE_WAIT,
    ST_INIT,
    ST_USER,
    ST_ERROR,
    ST_RESTART
  } load_state_e;

endpackage : config_loader_pkg

// ===== src/parallel_flash_config_loader.sv
// The address-and-strobe port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "config_loader_regs.svh"

module parallel_flash_config_loader
  import config_loader_pkg::*;
#(
  parameter int unsigned          CONFIG_WORDS    = 64,
  parameter logic [`CL_ADDR_W-1:0] START_ADDR     = `CL_FLASH_START_ADDR,
  parameter int unsigned          POR_FAST_CYCLES = `CL_POR_FAST_CYC,
  parameter int unsigned          POR_STD_CYCLES  = `CL_POR_STD_CYC,
  parameter int unsigned          RESTART_CYCLES  = `CL_RESTART_CYC
) (
  // Clock and reset
  input  wire logic                  SYS_CLK_I,
  input  wire logic                  SRST_I,
  // Straps and option pins
  input  wire logic                  SCHEME_FAST_I,
  input  wire logic                  AUTO_RESTART_I,
  input  wire logic                  USER_CLOCK_SEL_I,
  input  wire logic                  USER_INIT_CLOCK_I,
  // Board control lines, open drain
  input  wire logic                  CONFIG_REQUEST_N_I,
  input  wire logic                  CONFIG_STATUS_N_I,
  output logic                       CONFIG_STATUS_N_O,
  output logic                       CONFIG_STATUS_N_OE_O,
  input  wire logic                  CONFIG_COMPLETE_I,
  output logic                       CONFIG_COMPLETE_O,
  output logic                       CONFIG_COMPLETE_OE_O,
  output logic                       INIT_DONE_O,
  output logic                       INIT_DONE_OE_O,
  // Flash interface
  output logic                       CONFIG_CLOCK_OUT_O,
  output logic                       FLASH_HARD_RESET_N_O,
  output logic                       FLASH_CHIP_ENABLE_N_O,
  output logic                       FLASH_OUTPUT_ENABLE_N_O,
  output logic                       FLASH_ADDR_VALID_N_O,
  output logic                       FLASH_WRITE_ENABLE_N_O,
  output logic [`CL_ADDR_W-1:0]      FLASH_ADDR_BUS_O,
  input  wire logic [`CL_DATA_W-1:0] FLASH_DATA_I,
  output logic [`CL_DATA_W-1:0]      FLASH_DATA_O,
  output logic                       FLASH_DATA_OE_O,
  input  wire logic                  FLASH_WAIT_I,
  // Configuration stream to the fabric
  output logic [`CL_DATA_W-1:0]      CFG_WORD_O,
  output logic                       CFG_WORD_VALID_O,
  input  wire logic                  FRAME_ERROR_I,
  // User pin control
  output logic                       USER_MODE_O,
  output logic                       WEAK_PULLUP_EN_O
);

  // ==========================================================
  // Pin synchronisers
  localparam int SW = `CL_DATA_W + 7;

  logic [SW-1:0]         pin_raw;
  logic [SW-1:0]         pin_meta;
  logic [SW-1:0]         pin_sync;
  logic [`CL_DATA_W-1:0] data_s;
  logic                  req_s;
  logic                  status_s;
  logic                  done_s;
  logic                  uclk_s;
  logic                  fast_s;
  logic                  auto_s;
  logic                  usel_s;

  assign pin_raw = {FLASH_DATA_I, CONFIG_REQUEST_N_I, CONFIG_STATUS_N_I, CONFIG_COMPLETE_I,
                    USER_INIT_CLOCK_I, SCHEME_FAST_I, AUTO_RESTART_I, USER_CLOCK_SEL_I};

  // Two stages for every pin except the unused flash wait; only the second stage is read
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  assign data_s   = pin_sync[SW-1:7];
  assign req_s    = pin_sync[6];
  assign status_s = pin_sync[5];
  assign done_s   = pin_sync[4];
  assign uclk_s   = pin_sync[3];
  assign fast_s   = pin_sync[2];
  assign auto_s   = pin_sync[1];
  assign usel_s   = pin_sync[0];

  // ==========================================================
  // Sequencer state
  load_state_e           state;
  logic [31:0]           timer;
  logic [31:0]           word_cnt;
  logic [`CL_ADDR_W-1:0] addr;
  logic                  fast_por;
  logic                  init_en;
  logic [31:0]           init_cnt;
  logic [31:0]           osc_cnt;
  logic [31:0]           cfg_cnt;
  logic                  cfg_clk;
  logic                  uclk_prev;
  logic [31:0]           por_len;
  logic                  word_take;
  logic                  hdr_bad;
  logic                  frame_bad;
  logic                  last_word;
  logic                  osc_tick;
  logic                  uclk_edge;
  logic                  init_tick;
  logic                  in_cfg;

  assign por_len   = fast_por ? POR_FAST_CYCLES : POR_STD_CYCLES;
  assign word_take = (state == ST_DATA) && (timer == `CL_OE_WAIT_CYC - 1);
  assign hdr_bad   = (word_cnt == 0) &&
                     (data_s[`CL_HDR_SYNC_MSB:`CL_HDR_SYNC_LSB] != `CL_HDR_SYNC);
  assign frame_bad = hdr_bad || FRAME_ERROR_I;
  assign last_word = (word_cnt == CONFIG_WORDS - 1);
  assign in_cfg    = (state == ST_ADDR) || (state == ST_DATA);

  // Main stage sequencer; a low request overrides everything but power-on
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      state <= ST_POR;
      timer <= '0;
    end else if ((state != ST_POR) && !req_s) begin
      state <= ST_RESET;
      timer <= '0;
    end else begin
      unique case (state)
        ST_POR: begin
          // Strap is caught a few cycles in, once the synchroniser settled
          if ((timer >= por_len - 1) && (timer > `CL_STRAP_CYC)) begin
            state <= ST_RESET;
            timer <= '0;
          end else begin
            timer <= timer + 1;
          end
        end
        ST_RESET: begin
          if (req_s && status_s) begin
            state <= ST_ADDR;
            timer <= '0;
          end
        end
        ST_ADDR: begin
          if (timer == `CL_AVD_CYC - 1) begin
            state <= ST_DATA;
            timer <= '0;
          end else begin
            timer <= timer + 1;
          end
        end
        ST_DATA: begin
          // Fixed access window; the flash wait output is never consulted
          if (word_take) begin
            timer <= '0;
            if (frame_bad) begin
              state <= ST_ERROR;
            end else if (last_word) begin
              state <= ST_DONE_WAIT;
            end else begin
              state <= ST_ADDR;
            end
          end else begin
            timer <= timer + 1;
          end
        end
        ST_DONE_WAIT: begin
          if (done_s) begin
            state <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (init_tick && (init_cnt == `CL_INIT_CYCLES - 1)) begin
            state <= ST_USER;
          end
        end
        ST_USER: begin
          state <= ST_USER;
        end
        ST_ERROR: begin
          if (auto_s) begin
            state <= ST_RESTART;
            timer <= '0;
          end
        end
        ST_RESTART: begin
          if (timer == RESTART_CYCLES - 1) begin
            state <= ST_RESET;
            timer <= '0;
          end else begin
            timer <= timer + 1;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Power-on strap capture, after the synchroniser has settled
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      fast_por <= 1'b0;
    end else if ((state == ST_POR) && (timer == `CL_STRAP_CYC)) begin
      fast_por <= fast_s;
    end
  end

  // ==========================================================
  // Word address, word count and stream output
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      addr             <= START_ADDR;
      word_cnt         <= '0;
      CFG_WORD_O       <= '0;
      CFG_WORD_VALID_O <= 1'b0;
    end else begin
      CFG_WORD_VALID_O <= 1'b0;
      if ((state == ST_RESET) || (state == ST_POR)) begin
        addr     <= START_ADDR;
        word_cnt <= '0;
      end else if (word_take && !frame_bad) begin
        addr             <= addr + 24'h00_0001;
        word_cnt         <= word_cnt + 1;
        CFG_WORD_O       <= data_s;
        CFG_WORD_VALID_O <= 1'b1;
      end
    end
  end

  // Init-done enable comes from the first frame of each load
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      init_en <= 1'b0;
    end else if ((state == ST_RESET) || (state == ST_POR)) begin
      init_en <= 1'b0;
    end else if (word_take && !frame_bad && (word_cnt == 0)) begin
      init_en <= data_s[`CL_HDR_INITDONE_BIT];
    end
  end

  // ==========================================================
  // Initialisation clock: free internal divider or user clock edges
  assign osc_tick  = (osc_cnt == `CL_INIT_OSC_CYC - 1);
  assign uclk_edge = uclk_s && !uclk_prev;
  assign init_tick = usel_s ? uclk_edge : osc_tick;

  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      osc_cnt   <= '0;
      uclk_prev <= 1'b0;
    end else begin
      osc_cnt   <= osc_tick ? '0 : osc_cnt + 1;
      uclk_prev <= uclk_s;
    end
  end

  // A stalled user clock simply holds the count, delaying user mode
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      init_cnt <= '0;
    end else if (state != ST_INIT) begin
      init_cnt <= '0;
    end else if (init_tick) begin
      init_cnt <= init_cnt + 1;
    end
  end

  // ==========================================================
  // Configuration clock; rounds the rate down so the flash is never overdriven
  always_ff @(posedge SYS_CLK_I) begin
    if (SRST_I) begin
      cfg_cnt <= '0;
      cfg_clk <= 1'b0;
    end else if (in_cfg) begin
      cfg_cnt <= (cfg_cnt == `CL_CFG_CLK_CYC - 1) ? '0 : cfg_cnt + 1;
      cfg_clk <= (cfg_cnt < `CL_CFG_CLK_CYC / 2);
    end else begin
      cfg_cnt <= '0;
      cfg_clk <= 1'b0;
    end
  end

  assign CONFIG_CLOCK_OUT_O = cfg_clk;

  // ==========================================================
  // Flash strobes; read only, so write enable never falls
  assign FLASH_HARD_RESET_N_O    = !((state == ST_POR) || (state == ST_RESET));
  assign FLASH_CHIP_ENABLE_N_O   = !(in_cfg || (state == ST_ERROR) ||
                                     ((state == ST_RESTART) && (timer >= `CL_CE_PULSE_CYC)));
  assign FLASH_OUTPUT_ENABLE_N_O = !(state == ST_DATA);
  assign FLASH_ADDR_VALID_N_O    = !(state == ST_ADDR);
  assign FLASH_WRITE_ENABLE_N_O  = 1'b1;
  assign FLASH_ADDR_BUS_O        = addr;
  // Device never drives data, so no contention with the flash
  assign FLASH_DATA_O            = '0;
  assign FLASH_DATA_OE_O         = 1'b0;

  // ==========================================================
  // Open-drain board lines and user pin control
  assign CONFIG_STATUS_N_O    = 1'b0;
  assign CONFIG_STATUS_N_OE_O = (state == ST_POR) || (state == ST_ERROR) ||
                                (state == ST_RESTART) || !req_s;
  assign CONFIG_COMPLETE_O    = 1'b0;
  assign CONFIG_COMPLETE_OE_O = !((state == ST_DONE_WAIT) || (state == ST_INIT) ||
                                  (state == ST_USER)) || !req_s;
  assign INIT_DONE_O          = 1'b0;
  assign INIT_DONE_OE_O       = init_en && (in_cfg || (state == ST_DONE_WAIT) ||
                                            (state == ST_INIT));
  assign USER_MODE_O          = (state == ST_USER);
  assign WEAK_PULLUP_EN_O     = !((state == ST_POR) || (state == ST_USER));

  // ==========================================================
  // Checks
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (SRST_I);

  AST_AVD_WITH_CE: assert property (
    !FLASH_ADDR_VALID_N_O |-> !FLASH_CHIP_ENABLE_N_O && FLASH_OUTPUT_ENABLE_N_O
                              && FLASH_WRITE_ENABLE_N_O)
    else $error("address strobe without chip enable");

  AST_ADDR_STEP: assert property (
    (word_take && !frame_bad) |=> FLASH_ADDR_BUS_O == $past(FLASH_ADDR_BUS_O) + 24'h00_0001)
    else $error("flash address did not step by one");

  AST_NO_DRIVE_ON_READ: assert property (
    !FLASH_OUTPUT_ENABLE_N_O |-> !FLASH_DATA_OE_O)
    else $error("device drives data while flash reads");

  AST_POR_LENGTH: assert property (
    ($past(state) == ST_POR && state != ST_POR) |-> $past(timer) >= POR_FAST_CYCLES - 1)
    else $error("power-on hold too short");

  AST_POR_LINES: assert property (
    (state == ST_POR) |-> CONFIG_STATUS_N_OE_O && CONFIG_COMPLETE_OE_O && !USER_MODE_O)
    else $error("lines released during power-on");

  AST_USER_PULLUPS: assert property (
    (state == ST_USER) |-> !WEAK_PULLUP_EN_O && !INIT_DONE_OE_O)
    else $error("pull-ups or init-done held in user mode");

  AST_RESET_HOLD: assert property (
    (state == ST_RESET && !(req_s && status_s)) |=> state == ST_RESET)
    else $error("left reset with request or status low");

  AST_CFG_CLOCK_RUNS: assert property (
    (in_cfg && $past(in_cfg) && $past(in_cfg, 2) && $past(in_cfg, 3))
      |-> !((cfg_clk == $past(cfg_clk)) && (cfg_clk == $past(cfg_clk, 2))))
    else $error("configuration clock stalled while loading");

  AST_INIT_AFTER_DONE: assert property (
    (state == ST_DONE_WAIT && !done_s) |=> state != ST_INIT)
    else $error("initialisation began before done sensed high");

  AST_INIT_COUNT: assert property (
    $rose(state == ST_USER) |-> $past(init_cnt) == `CL_INIT_CYCLES - 1)
    else $error("user mode entered after wrong init count");

  AST_INIT_HOLD: assert property (
    (state == ST_INIT && usel_s && !uclk_edge) |=> init_cnt == $past(init_cnt) ||
                                                     state != ST_INIT)
    else $error("init count moved without user clock edge");

  AST_ERROR_LINES: assert property (
    (state == ST_ERROR) |-> CONFIG_STATUS_N_OE_O && CONFIG_COMPLETE_OE_O)
    else $error("error without status and done held low");

  AST_RESTART_PULSE: assert property (
    $rose(state == ST_RESTART) |-> FLASH_CHIP_ENABLE_N_O [*8])
    else $error("chip enable not pulsed on restart");

  AST_RESTART_TIME: assert property (
    (state == ST_RESTART && timer == RESTART_CYCLES - 1 && req_s) |=>
      state == ST_RESET && !CONFIG_STATUS_N_OE_O)
    else $error("status not released at restart timeout");

  AST_REQUEST_RESETS: assert property (
    (!req_s && state != ST_POR) |-> CONFIG_STATUS_N_OE_O && CONFIG_COMPLETE_OE_O ##1
      state == ST_RESET && CONFIG_COMPLETE_OE_O && !USER_MODE_O)
    else $error("request low did not reset the loader");

  AST_RELOAD_START: assert property (
    (state == ST_ADDR && $past(state) == ST_RESET) |-> $past(req_s) && $past(status_s))
    else $error("reload began without request and status high");

  COV_USER_MODE: cover property ($rose(state == ST_USER));
  COV_AUTO_RESTART: cover property ((state == ST_RESTART) ##1 (state == ST_RESET));
  COV_RELOAD_FROM_USER: cover property ((state == ST_USER) ##1 (state == ST_RESET));
  COV_INIT_DONE_LOW: cover property ($rose(INIT_DONE_OE_O));

endmodule : parallel_flash_config_loader

// ===== bench/flash_model.sv
`timescale 1ns/1ps
// ==========================================================
// Parallel flash partner, asynchronous read only
module flash_model #(
  parameter logic [23:0] START_ADDR = 24'h00_0000
) (
  // Clock for the released-bus pattern
  input  wire logic        clk_i,
  // Strobes and address from the loader
  input  wire logic        hard_reset_n_i,
  input  wire logic        chip_enable_n_i,
  input  wire logic        output_enable_n_i,
  input  wire logic        addr_valid_n_i,
  input  wire logic        write_enable_n_i,
  input  wire logic [23:0] addr_i,
  // Data and wait back to the loader
  output logic [15:0]      data_o,
  output logic             wait_o
);
  logic [23:0] addr_q;
  logic [15:0] idle;

  // Header word at the start address, a pattern elsewhere
  function automatic logic [15:0] word_at(input logic [23:0] a);
    return (a == START_ADDR) ? 16'h5A01 : (a[15:0] ^ 16'hC3A5);
  endfunction : word_at

  initial begin
    idle = 16'h0000;
    wait_o = 1'b0;
    addr_q = 24'h00_0000;
  end

  // Address is written while the valid strobe is low
  always @(posedge clk_i) begin
    if (!addr_valid_n_i && !chip_enable_n_i && write_enable_n_i) addr_q <= addr_i;
  end

  // Drives only while selected and output-enabled; else a flipping value
  assign data_o = (hard_reset_n_i && !chip_enable_n_i && !output_enable_n_i) ?
                  word_at(addr_q) : idle;

  // Wait toggles freely so a loader that listens would misbehave
  always @(posedge clk_i) begin
    idle <= ~data_o;
    wait_o <= ~wait_o;
  end
endmodule : flash_model

// ===== bench/parallel_flash_config_loader_bench.sv
`timescale 1ns/1ps
module parallel_flash_config_loader_bench;
  localparam int WORDS = 8;
  localparam int POR_F = 20;
  localparam int POR_S = 40;
  localparam int RST = 200;
  localparam logic [23:0] START = 24'h00_0000;
  logic sys_clk, srst, fast, auto_rs, usel, uclk, uclk_run, req_n, ferr, wait_w;
  logic st_o, st_oe, dn_o, dn_oe, id_o, id_oe, cclk, hrst_n, ce_n, oe_n, avd_n;
  logic we_n, d_oe, valid, umode, pull, avd_prev;
  logic [23:0] addr, prev, lastaddr;
  logic [15:0] fdata, d_o, word;
  int n_fail, checks, seed, n_words, k, w0, n_clk;

  // ==========================================================
  // Clocks; the init clock is unrelated in phase
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    uclk = 1'b0;
    #3.1;
    forever #62.5 uclk = uclk_run ? ~uclk : 1'b0;
  end

  parallel_flash_config_loader #(.CONFIG_WORDS(WORDS), .START_ADDR(START),
    .POR_FAST_CYCLES(POR_F), .POR_STD_CYCLES(POR_S), .RESTART_CYCLES(RST)) uut (
    .SYS_CLK_I(sys_clk), .SRST_I(srst), .SCHEME_FAST_I(fast),
    .AUTO_RESTART_I(auto_rs), .USER_CLOCK_SEL_I(usel), .USER_INIT_CLOCK_I(uclk),
    .CONFIG_REQUEST_N_I(req_n), .CONFIG_STATUS_N_I(~st_oe), .CONFIG_STATUS_N_O(st_o),
    .CONFIG_STATUS_N_OE_O(st_oe), .CONFIG_COMPLETE_I(~dn_oe), .CONFIG_COMPLETE_O(dn_o),
    .CONFIG_COMPLETE_OE_O(dn_oe), .INIT_DONE_O(id_o), .INIT_DONE_OE_O(id_oe),
    .CONFIG_CLOCK_OUT_O(cclk), .FLASH_HARD_RESET_N_O(hrst_n),
    .FLASH_CHIP_ENABLE_N_O(ce_n), .FLASH_OUTPUT_ENABLE_N_O(oe_n),
    .FLASH_ADDR_VALID_N_O(avd_n), .FLASH_WRITE_ENABLE_N_O(we_n),
    .FLASH_ADDR_BUS_O(addr), .FLASH_DATA_I(fdata), .FLASH_DATA_O(d_o),
    .FLASH_DATA_OE_O(d_oe), .FLASH_WAIT_I(wait_w), .CFG_WORD_O(word),
    .CFG_WORD_VALID_O(valid), .FRAME_ERROR_I(ferr), .USER_MODE_O(umode),
    .WEAK_PULLUP_EN_O(pull));

  flash_model #(.START_ADDR(START)) flash (.clk_i(sys_clk), .hard_reset_n_i(hrst_n),
    .chip_enable_n_i(ce_n), .output_enable_n_i(oe_n), .addr_valid_n_i(avd_n),
    .write_enable_n_i(we_n), .addr_i(addr), .data_o(fdata), .wait_o(wait_w));

  // ==========================================================
  // Helpers
  function automatic logic [15:0] exp_word(input logic [23:0] a);
    return (a == START) ? 16'h5A01 : (a[15:0] ^ 16'hC3A5);
  endfunction : exp_word

  task check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc

  // Bounded wait on a settled output; n returns the cycles spent
  task automatic wait_for(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    #1;
    while (s !== v && n < lim) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    check(s, v, "bounded wait");
  endtask : wait_for

  // Fetch monitor: address steps and accepted words
  always @(posedge sys_clk) begin
    avd_prev <= avd_n;
    if (!oe_n) lastaddr <= addr;
    if (!avd_n && avd_prev === 1'b1 && !srst) begin
      if (addr !== START) check(addr, prev + 24'd1, "address step");
      prev <= addr;
    end
    if (valid === 1'b1) begin
      check(word, exp_word(lastaddr), "word taken");
      check({d_oe, we_n}, 2'b01, "no flash write");
      check({st_o, dn_o, id_o}, 3'b000, "open-drain drive level");
      n_words++;
    end
    // One config clock high phase in every three-cycle address phase
    if (!avd_n && cclk === 1'b1) n_clk++;
    if (avd_n === 1'b1 && avd_prev === 1'b0 && !srst) begin
      check(n_clk, 1, "config clock rate");
      n_clk = 0;
    end
  end

  task por(input logic f, input int n);
    @(posedge sys_clk);
    fast <= f;
    srst <= 1'b1;
    cyc(4);
    #1;
    check({st_oe, dn_oe, hrst_n, umode, id_oe}, 5'b11000, "reset levels");
    @(posedge sys_clk);
    srst <= 1'b0;
    wait_for(st_oe, 1'b0, n + 30, k);
    check(k >= n, 1, "power-on length");
    $display("test por %0d done", n);
  endtask : por

  // Frame error on word index i, held until status drops
  task inject(input int i);
    int n;
    n = 0;
    while (!(addr == START + i && !oe_n) && n < 500) begin
      @(posedge sys_clk);
      n++;
    end
    ferr <= 1'b1;
    wait_for(st_oe, 1'b1, 40, n);
    @(posedge sys_clk);
    ferr <= 1'b0;
    check(dn_oe, 1, "done held on error");
  endtask : inject

  task req_pulse(input int w);
    @(posedge sys_clk);
    req_n <= 1'b0;
    cyc(4);
    #1;
    check({st_oe, dn_oe, hrst_n, umode}, 4'b1100, "request low");
    cyc(w);
    req_n <= 1'b1;
    w0 = n_words;
    wait_for(st_oe, 1'b0, 20, k);
  endtask : req_pulse

  task finish_init(input int exp, input string name);
    wait_for(dn_oe, 1'b0, 2000, k);
    // Last word's valid pulse is counted by the monitor one edge later
    @(posedge sys_clk);
    #1;
    check(n_words - w0, WORDS, "words loaded");
    check({id_oe, pull, umode}, 3'b110, "init levels");
    wait_for(umode, 1'b1, exp + 100, k);
    check(k >= exp - 20 && k <= exp + 50, 1, "init length");
    check({id_oe, pull}, 2'b00, "user levels");
    $display("test %s done", name);
  endtask : finish_init

  task stop_test;
    $display("counts: %0d checks, %0d mismatches", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  // ==========================================================
  // Watchdog, sized past both full initialisations
  initial begin
    #1_000_000;
    n_fail++;
    stop_test;
  end

  // Main sequence
  initial begin
    {n_fail, checks, n_words, w0, k, n_clk} = '0;
    seed = 33;
    {srst, fast, auto_rs, usel, uclk_run, ferr} = 6'b100000;
    req_n = 1'b1;
    prev = START;
    lastaddr = START;
    avd_prev = 1'b1;
    por(1'b0, POR_S);
    por(1'b1, POR_F);
    // Error without auto-restart: status stays low until a request pulse
    inject(($unsigned($random(seed)) % (WORDS - 1)) + 1);
    cyc(300);
    #1;
    check(st_oe, 1, "status held");
    req_pulse(50 + $unsigned($random(seed)) % 20);
    finish_init(31800, "internal clock");
    // Auto-restart, then reload under the user clock
    @(posedge sys_clk);
    auto_rs <= 1'b1;
    usel <= 1'b1;
    uclk_run <= 1'b1;
    req_pulse(50 + $unsigned($random(seed)) % 20);
    inject(($unsigned($random(seed)) % (WORDS - 1)) + 1);
    wait_for(ce_n, 1'b1, 10, k);
    wait_for(st_oe, 1'b0, RST + 40, k);
    check(k <= RST + 40, 1, "restart timeout");
    w0 = n_words;
    finish_init(39750, "user clock");
    stop_test;
  end
endmodule : parallel_flash_config_loader_bench
